// [common/slfc_pkg.sv]
// Package: register map, field positions, modes and timing for segment LCD frame control
package slfc_pkg;
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_FRAME_RATE = 4'h2;
  localparam logic [3:0] ADDR_CONTRAST = 4'h3;
  localparam logic [3:0] ADDR_ASYNC_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DISP_BASE = 4'h8;
  localparam int NUM_DISP_BYTES = 4;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] FRAME_RATE_RESET = 8'h00;
  localparam logic [7:0] CONTRAST_RESET = 8'h00;
  localparam logic [7:0] ASYNC_STATUS_RESET = 8'h00;
  localparam int BIT_CONTROLLER_ON = 7;
  localparam int BIT_LOW_POWER_WAVE = 6;
  localparam int BIT_FRAME_FLAG = 4;
  localparam int BIT_IRQ_ENABLE = 3;
  localparam int BIT_BLANK = 0;
  localparam int BIT_CLK_SRC = 7;
  localparam int BIT_HALF_BIAS = 6;
  localparam int BIT_DUTY_LO = 4;
  localparam int BIT_PMASK_LO = 0;
  localparam int BIT_EXT_CLK_EN = 6;
  localparam logic [7:0] CTRL_A_RD_MASK = 8'hD9;
  localparam logic [7:0] CTRL_B_RD_MASK = 8'hF7;
  localparam logic [7:0] FRAME_RATE_RD_MASK = 8'h7F;
  localparam logic [7:0] ASYNC_RD_MASK = 8'h40;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 25;
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam int PHASE_CYCLES_MIN = 1;
  localparam logic [7:0] DIV_BASE = 8'h02;
  typedef enum logic [1:0] {SLFC_OFF, SLFC_RUN, SLFC_BLANKED} slfc_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } slfc_bus_s;
  typedef struct packed {
    logic [1:0] level;
    logic drive;
  } slfc_pin_s;
endpackage

// [verilog/slfc_frame_ctrl.sv]
// Segment LCD frame controller: registers, frame latching, pin level sequencing
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Low power wave bit selects reduced-toggle waveform on pins.
// - Low power mode latches data and sets flag every second frame.
// - Sync clock source keeps running in idle and power-save.
// - Async clock with RC system clock keeps running idle, ADC-NR, power-save.
// - External clock enable with async source enables input buffer.
// - Blank finishes frame then grounds all segment and common pins.
// - Display memory unchanged while blanked.
// - Port mask returns unused segment pins to port function.
// - Commons unused by duty return to port function automatically.
// - Memory, blank, wave select, contrast latched before each frame, every second frame in low power.
// - Writes accepted anytime clk_en is high; updates may split across frames.
// - Disable returns pins to port; software keeps them safe.
// - Writing one to frame flag clears it.
// - Frame flag set at frame start with data latch.
// - Wave select change takes effect at next frame latch.
// - Duty field picks static, 1/2, 1/3, 1/4 with commons.
// - Clock source bit: zero system clock, one async clock.
module slfc_frame_ctrl
  import slfc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire slfc_bus_s bus_in,
  input wire logic async_tick,
  output logic [7:0] rd_data,
  output slfc_pin_s [NUM_COM-1:0] com_pin,
  output slfc_pin_s [NUM_SEG-1:0] seg_pin,
  output logic [7:0] contrast_active,
  output logic ext_buf_en,
  output logic frame_irq
);
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] frame_rate_r;
  logic [7:0] contrast_r;
  logic [7:0] async_r;
  logic [7:0] disp_mem [NUM_DISP_BYTES*NUM_COM];
  logic [7:0] disp_lat [NUM_DISP_BYTES*NUM_COM];
  logic lat_blank_r;
  logic lat_lpw_r;
  logic [7:0] div_cnt_r;
  logic [1:0] com_idx_r;
  logic polarity_r;
  logic odd_frame_r;
  logic [1:0] lpw_gap_r;
  slfc_state_e state_r;
  logic tick;
  logic step;
  logic frame_end;
  logic latch_now;
  logic flag_clr;
  logic [1:0] duty;
  logic [1:0] last_com;

  function automatic logic [4:0] seg_count(input logic [2:0] pm);
    case (pm)
      3'h0: seg_count = 5'd13;
      3'h1: seg_count = 5'd15;
      3'h2: seg_count = 5'd17;
      3'h3: seg_count = 5'd19;
      3'h4: seg_count = 5'd21;
      3'h5: seg_count = 5'd23;
      3'h6: seg_count = 5'd24;
      default: seg_count = 5'd25;
    endcase
  endfunction

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] target);
    is_addr = (a == target);
  endfunction

  // Chosen clock: system clock ticks or async ticks
  assign tick = ctrl_b_r[BIT_CLK_SRC] ? async_tick : 1'b1;
  assign duty = ctrl_b_r[BIT_DUTY_LO +: 2];
  assign last_com = duty;
  assign step = clk_en && tick && ctrl_a_r[BIT_CONTROLLER_ON] && (div_cnt_r >= (frame_rate_r | DIV_BASE));
  assign frame_end = step && (com_idx_r == last_com) && polarity_r;
  // Low power waveform needs two equal frames, so latch every second one
  assign latch_now = frame_end && (!lat_lpw_r || odd_frame_r);
  assign flag_clr = clk_en && bus_in.wr && is_addr(bus_in.addr, ADDR_CTRL_A) && bus_in.wdata[BIT_FRAME_FLAG];

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_a_r <= CTRL_A_RESET;
      ctrl_b_r <= CTRL_B_RESET;
      frame_rate_r <= FRAME_RATE_RESET;
      contrast_r <= CONTRAST_RESET;
      async_r <= ASYNC_STATUS_RESET;
    end else if (clk_en) begin
      if (bus_in.wr) begin
        if (is_addr(bus_in.addr, ADDR_CTRL_A)) begin
          ctrl_a_r[BIT_CONTROLLER_ON] <= bus_in.wdata[BIT_CONTROLLER_ON];
          ctrl_a_r[BIT_LOW_POWER_WAVE] <= bus_in.wdata[BIT_LOW_POWER_WAVE];
          ctrl_a_r[BIT_IRQ_ENABLE] <= bus_in.wdata[BIT_IRQ_ENABLE];
          ctrl_a_r[BIT_BLANK] <= bus_in.wdata[BIT_BLANK];
        end else if (is_addr(bus_in.addr, ADDR_CTRL_B)) begin
          ctrl_b_r <= bus_in.wdata & CTRL_B_RD_MASK;
        end else if (is_addr(bus_in.addr, ADDR_FRAME_RATE)) begin
          frame_rate_r <= bus_in.wdata & FRAME_RATE_RD_MASK;
        end else if (is_addr(bus_in.addr, ADDR_CONTRAST)) begin
          contrast_r <= bus_in.wdata;
        end else if (is_addr(bus_in.addr, ADDR_ASYNC_STATUS)) begin
          async_r <= bus_in.wdata & ASYNC_RD_MASK;
        end
      end
      // Set beats clear so a frame start is never lost
      if (latch_now) begin
        ctrl_a_r[BIT_FRAME_FLAG] <= 1'b1;
      end else if (flag_clr) begin
        ctrl_a_r[BIT_FRAME_FLAG] <= 1'b0;
      end
      if (!ctrl_a_r[BIT_CONTROLLER_ON]) begin
        ctrl_a_r[BIT_FRAME_FLAG] <= ctrl_a_r[BIT_FRAME_FLAG] & ~flag_clr;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Display memory, software side; blanking never touches it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_DISP_BYTES*NUM_COM; i++) begin
        disp_mem[i] <= 8'h00;
      end
    end else if (clk_en && bus_in.wr && bus_in.addr >= ADDR_DISP_BASE) begin
      disp_mem[bus_in.addr - ADDR_DISP_BASE] <= bus_in.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame latch of data and settings
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_DISP_BYTES*NUM_COM; i++) begin
        disp_lat[i] <= 8'h00;
      end
      lat_blank_r <= 1'b0;
      lat_lpw_r <= 1'b0;
      contrast_active <= CONTRAST_RESET;
    end else if (clk_en && (latch_now || !ctrl_a_r[BIT_CONTROLLER_ON])) begin
      disp_lat <= disp_mem;
      lat_blank_r <= ctrl_a_r[BIT_BLANK];
      lat_lpw_r <= ctrl_a_r[BIT_LOW_POWER_WAVE];
      contrast_active <= contrast_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame timing: common index, phase polarity, frame parity
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_cnt_r <= 8'h00;
      com_idx_r <= 2'h0;
      polarity_r <= 1'b0;
      odd_frame_r <= 1'b0;
      state_r <= SLFC_OFF;
    end else if (clk_en) begin
      if (!ctrl_a_r[BIT_CONTROLLER_ON]) begin
        div_cnt_r <= 8'h00;
        com_idx_r <= 2'h0;
        polarity_r <= 1'b0;
        odd_frame_r <= 1'b0;
        state_r <= SLFC_OFF;
      end else begin
        if (step) begin
          div_cnt_r <= 8'h00;
        end else if (tick) begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
        if (step) begin
          // Default waveform flips every phase, twice per common; low power flips once per pass over the commons
          if (lat_lpw_r) begin
            if (com_idx_r == last_com) begin
              com_idx_r <= 2'h0;
              polarity_r <= ~polarity_r;
            end else begin
              com_idx_r <= com_idx_r + 2'h1;
            end
          end else begin
            polarity_r <= ~polarity_r;
            if (polarity_r) begin
              com_idx_r <= (com_idx_r == last_com) ? 2'h0 : com_idx_r + 2'h1;
            end
          end
        end
        if (frame_end) begin
          // Restart the pair at each latch so a switch into low power still waits two frames
          odd_frame_r <= !latch_now;
        end
        case (state_r)
          SLFC_OFF: state_r <= SLFC_RUN;
          // Follow the latched copy so blanking starts and ends on frame boundaries
          SLFC_RUN: if (lat_blank_r) state_r <= SLFC_BLANKED;
          SLFC_BLANKED: if (!lat_blank_r) state_r <= SLFC_RUN;
          default: state_r <= SLFC_OFF;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin levels: 0 ground, 3 full, 1/2 intermediate bias levels
  generate
    for (genvar c = 0; c < NUM_COM; c++) begin : g_com
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          com_pin[c] <= '0;
        end else if (clk_en) begin
          com_pin[c].drive <= ctrl_a_r[BIT_CONTROLLER_ON] && (c <= int'(last_com));
          if (state_r != SLFC_RUN) begin
            com_pin[c].level <= 2'h0;
          end else if (c == int'(com_idx_r)) begin
            com_pin[c].level <= polarity_r ? 2'h0 : 2'h3;
          end else if (duty == DUTY_STATIC) begin
            com_pin[c].level <= 2'h0;
          end else if (ctrl_b_r[BIT_HALF_BIAS]) begin
            com_pin[c].level <= 2'h1;
          end else begin
            com_pin[c].level <= polarity_r ? 2'h1 : 2'h2;
          end
        end
      end
    end
    for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      logic on;
      assign on = disp_lat[int'(com_idx_r)*NUM_DISP_BYTES + s/8][s%8];
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          seg_pin[s] <= '0;
        end else if (clk_en) begin
          seg_pin[s].drive <= ctrl_a_r[BIT_CONTROLLER_ON] && (s < int'(seg_count(ctrl_b_r[BIT_PMASK_LO +: 3])));
          if (state_r != SLFC_RUN) begin
            seg_pin[s].level <= 2'h0;
          end else if (on) begin
            seg_pin[s].level <= polarity_r ? 2'h3 : 2'h0;
          end else if (duty == DUTY_STATIC || ctrl_b_r[BIT_HALF_BIAS]) begin
            seg_pin[s].level <= polarity_r ? 2'h0 : 2'h3;
          end else begin
            seg_pin[s].level <= polarity_r ? 2'h2 : 2'h1;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read port, misc outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
      ext_buf_en <= 1'b0;
      frame_irq <= 1'b0;
    end else if (clk_en) begin
      ext_buf_en <= async_r[BIT_EXT_CLK_EN] && ctrl_b_r[BIT_CLK_SRC];
      frame_irq <= ctrl_a_r[BIT_FRAME_FLAG] && ctrl_a_r[BIT_IRQ_ENABLE];
      if (bus_in.rd) begin
        if (is_addr(bus_in.addr, ADDR_CTRL_A)) begin
          rd_data <= ctrl_a_r & CTRL_A_RD_MASK;
        end else if (is_addr(bus_in.addr, ADDR_CTRL_B)) begin
          rd_data <= ctrl_b_r;
        end else if (is_addr(bus_in.addr, ADDR_FRAME_RATE)) begin
          rd_data <= frame_rate_r;
        end else if (is_addr(bus_in.addr, ADDR_CONTRAST)) begin
          rd_data <= contrast_r;
        end else if (is_addr(bus_in.addr, ADDR_ASYNC_STATUS)) begin
          rd_data <= async_r;
        end else if (bus_in.addr >= ADDR_DISP_BASE) begin
          rd_data <= disp_mem[bus_in.addr - ADDR_DISP_BASE];
        end else begin
          rd_data <= 8'h00;
        end
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && flag_clr && !latch_now) |=> !ctrl_a_r[BIT_FRAME_FLAG])
    else $error("frame flag not cleared by write of one");
  chk_flag_set: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && latch_now) |=> ctrl_a_r[BIT_FRAME_FLAG])
    else $error("frame flag not set at frame start");
  // Frame ends since the last latch, counted apart from the parity flop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lpw_gap_r <= 2'h0;
    end else if (clk_en) begin
      if (latch_now || !ctrl_a_r[BIT_CONTROLLER_ON]) begin
        lpw_gap_r <= 2'h0;
      end else if (frame_end && lpw_gap_r != 2'h3) begin
        lpw_gap_r <= lpw_gap_r + 2'h1;
      end
    end
  end
  chk_lpw_alternate: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && latch_now && lat_lpw_r) |-> lpw_gap_r == 2'h1)
    else $error("low power mode latched without two equal frames");
  chk_blank_ground: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_r == SLFC_BLANKED) |=> (com_pin[0].level == 2'h0 && seg_pin[0].level == 2'h0))
    else $error("blanked pins not grounded");
  chk_com_unused: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && duty == DUTY_STATIC) |=> !com_pin[1].drive)
    else $error("unused common driven in static duty");
  chk_seg_mask: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && ctrl_b_r[BIT_PMASK_LO +: 3] == 3'h0) |=> !seg_pin[13].drive)
    else $error("masked segment still driven");
  chk_ext_buf: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && async_r[BIT_EXT_CLK_EN] && ctrl_b_r[BIT_CLK_SRC]) |=> ext_buf_en)
    else $error("external clock buffer not enabled");
  chk_off_release: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !ctrl_a_r[BIT_CONTROLLER_ON]) |=> !com_pin[0].drive)
    else $error("pins driven while controller off");
  chk_blank_mem: assert property (@(posedge ref_clk) disable iff (reset)
    (state_r == SLFC_BLANKED && !bus_in.wr) |=> disp_mem[0] == $past(disp_mem[0]))
    else $error("display memory changed while blanked");
endmodule

// [testbench/slfc_glass_model.sv]
// Passive glass model: pin ownership, ground check and DC sum across seg0/com0
`timescale 1ns/1ns
module slfc_glass_model
  import slfc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire slfc_pin_s [NUM_COM-1:0] com_pin,
  input wire slfc_pin_s [NUM_SEG-1:0] seg_pin,
  output logic [2:0] com_owned,
  output logic [4:0] seg_owned,
  output logic all_ground,
  output logic signed [15:0] dc_sum_r
);
  // Released pins are port pins; the glass ignores them
  always_comb begin
    com_owned = 3'h0;
    seg_owned = 5'h0;
    all_ground = 1'b1;
    for (int i = 0; i < NUM_COM; i++) begin
      com_owned = com_owned + 3'(com_pin[i].drive);
      if (com_pin[i].drive && com_pin[i].level != 2'h0) all_ground = 1'b0;
    end
    for (int i = 0; i < NUM_SEG; i++) begin
      seg_owned = seg_owned + 5'(seg_pin[i].drive);
      if (seg_pin[i].drive && seg_pin[i].level != 2'h0) all_ground = 1'b0;
    end
  end
  // Net charge on one cell; must return to its start over every full frame
  always_ff @(posedge ref_clk) begin
    if (reset) dc_sum_r <= 16'sh0000;
    else if (com_pin[0].drive && seg_pin[0].drive)
      dc_sum_r <= dc_sum_r + $signed({14'h0000, seg_pin[0].level}) - $signed({14'h0000, com_pin[0].level});
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the segment LCD frame controller
`timescale 1ns/1ns
module tb;
  import slfc_pkg::*;
  logic ref_clk, reset, clk_en, async_tick, tick_on, ext_buf_en, frame_irq, all_ground;
  slfc_bus_s bus;
  logic [7:0] rd_data, contrast_active, d, ctl_a;
  slfc_pin_s [NUM_COM-1:0] com_pin;
  slfc_pin_s [NUM_SEG-1:0] seg_pin;
  logic [2:0] com_owned;
  logic [4:0] seg_owned;
  logic signed [15:0] dc_sum_r, s;
  int err_total, n_checks, cyc, t0, tdef;
  slfc_frame_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .bus_in(bus),
    .async_tick(async_tick), .rd_data(rd_data), .com_pin(com_pin), .seg_pin(seg_pin),
    .contrast_active(contrast_active), .ext_buf_en(ext_buf_en), .frame_irq(frame_irq));
  slfc_glass_model glass_u (.ref_clk(ref_clk), .reset(reset), .com_pin(com_pin), .seg_pin(seg_pin),
    .com_owned(com_owned), .seg_owned(seg_owned), .all_ground(all_ground), .dc_sum_r(dc_sum_r));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Slow async source: one tick every second system cycle
  always @(posedge ref_clk) async_tick <= tick_on & ~async_tick;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    // Let a flag clear written just before reach frame_irq
    repeat (2) @(posedge ref_clk);
    while (frame_irq !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(16'(n < 400), 16'h0001);
  endtask
  // Clear the flag, then wait for the next frame start
  task automatic next_frame();
    wr(ADDR_CTRL_A, ctl_a | 8'h10);
    wait_irq();
  endtask
  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(4'h5, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), d);
      check(16'(d), 16'h0000);
    end
    check(16'({com_owned, seg_owned, ext_buf_en}), 16'h0000);
  endtask
  task automatic t_ports();
    logic [4:0] segs [8] = '{5'd13, 5'd15, 5'd17, 5'd19, 5'd21, 5'd23, 5'd24, 5'd25};
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_B, {2'h0, 2'(k % 4), 1'b0, 3'(k)});
      wr(ADDR_CTRL_A, 8'h80);
      repeat (3) @(posedge ref_clk);
      check(16'(com_owned), 16'(k % 4 + 1));
      check(16'(com_owned), 16'(k % 4 + 1));
      check(16'(seg_owned), 16'(segs[k]));
    end
    wr(ADDR_CTRL_A, 8'h00);
    repeat (3) @(posedge ref_clk);
    check(16'({com_owned, seg_owned}), 16'h0000);
  endtask
  task automatic t_frame();
    wr(ADDR_CTRL_B, 8'h37);
    wr(ADDR_FRAME_RATE, 8'h00);
    wr(ADDR_DISP_BASE, 8'hFF);
    ctl_a = 8'h88;
    wr(ADDR_CTRL_A, ctl_a);
    wait_irq();
    wr(ADDR_CTRL_A, 8'h98);
    rd(ADDR_CTRL_A, d);
    check(16'(d), 16'h0088);
    wr(ADDR_CONTRAST, 8'h5A);
    check(16'(contrast_active), 16'h0000);
    wait_irq();
    check(16'(contrast_active), 16'h005A);
    s = dc_sum_r;
    t0 = cyc;
    next_frame();
    tdef = cyc - t0;
    check(16'(tdef), 16'(NUM_COM * 2 * 3));
    check(16'(dc_sum_r - s), 16'h0000);
    ctl_a = 8'hC8;
    next_frame();
    next_frame();
    s = dc_sum_r;
    t0 = cyc;
    next_frame();
    check(16'(cyc - t0), 16'(2 * tdef));
    check(16'(dc_sum_r - s), 16'h0000);
  endtask
  task automatic t_blank();
    ctl_a = 8'h88;
    next_frame();
    wr(ADDR_DISP_BASE, 8'hA5);
    wr(ADDR_DISP_BASE + 4'h7, 8'h3C);
    ctl_a = 8'h89;
    wr(ADDR_CTRL_A, 8'h99);
    check(16'(all_ground), 16'h0000);
    wait_irq();
    repeat (3) @(posedge ref_clk);
    check(16'(all_ground), 16'h0001);
    rd(ADDR_DISP_BASE, d);
    check(16'(d), 16'h00A5);
    rd(ADDR_DISP_BASE + 4'h7, d);
    check(16'(d), 16'h003C);
    ctl_a = 8'h88;
    next_frame();
    next_frame();
    repeat (3) @(posedge ref_clk);
    check(16'(all_ground), 16'h0000);
    // Safe shutdown: blank with flag clear, wait for the blanked frame, then switch off
    ctl_a = 8'h89;
    next_frame();
    repeat (3) @(posedge ref_clk);
    check(16'(all_ground), 16'h0001);
    wr(ADDR_CTRL_A, 8'h00);
    repeat (3) @(posedge ref_clk);
    check(16'({com_owned, seg_owned}), 16'h0000);
    // Stopped clock only after switch-off; a write meanwhile must not land
    clk_en <= 1'b0;
    wr(ADDR_CONTRAST, 8'hC3);
    repeat (20) @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(ADDR_CONTRAST, d);
    check(16'(d), 16'h005A);
  endtask
  task automatic t_async();
    wr(ADDR_CTRL_B, 8'hB7);
    wr(ADDR_ASYNC_STATUS, 8'h40);
    rd(ADDR_ASYNC_STATUS, d);
    check(16'(d), 16'h0040);
    check(16'(ext_buf_en), 16'h0001);
    ctl_a = 8'h88;
    wr(ADDR_CTRL_A, 8'h98);
    // No async edges, so no frame may start
    repeat (200) @(posedge ref_clk);
    check(16'(frame_irq), 16'h0000);
    tick_on <= 1'b1;
    wait_irq();
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h37);
    repeat (3) @(posedge ref_clk);
    check(16'(ext_buf_en), 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    tick_on = 1'b0;
    async_tick = 1'b0;
    bus = '0;
    cyc = 0;
    err_total = 0;
    n_checks = 0;
    ctl_a = 8'h00;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_ports();
    t_frame();
    t_blank();
    t_async();
    stop_test();
  end
  // Whole run needs under a thousand cycles
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule
